// file: rtl/dcb_pkg.sv
// Package of constants and types for the channel binding and Nco_phase_sync_control block.
package dcb_pkg;
  localparam int ADDR_W = 12;
  localparam int SAMPLE_W = 12;
  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_ROUTE = 12'h216;
  localparam logic [ADDR_W-1:0] IDX_REF_DIV = 12'h217;
  localparam logic [ADDR_W-1:0] IDX_SYNC_CTL = 12'h219;
  localparam logic [ADDR_W-1:0] IDX_PATH_CTL = 12'h21A;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h21B;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE = ADDR_W'(IDX_ROUTE * 4);
  localparam logic [ADDR_W-1:0] ADDR_REF_DIV = ADDR_W'(IDX_REF_DIV * 4);
  localparam logic [ADDR_W-1:0] ADDR_SYNC_CTL = ADDR_W'(IDX_SYNC_CTL * 4);
  localparam logic [ADDR_W-1:0] ADDR_PATH_CTL = ADDR_W'(IDX_PATH_CTL * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);
  // Values after reset.
  localparam logic [7:0] RST_ROUTE = 8'h02;
  localparam logic [15:0] RST_REF_DIV = 16'h0000;
  localparam logic [7:0] RST_SYNC_CTL = 8'h02;
  localparam logic [7:0] RST_PATH_CTL = 8'h00;
  // Field positions.
  localparam int BIT_ROUTE_A = 0;
  localparam int BIT_ROUTE_B = 1;
  localparam int BIT_SYSREF_ARM = 0;
  localparam int BIT_ALIGN_SYNC = 1;
  localparam int BIT_LINK_EN = 0;
  localparam int BIT_CAL_EN = 1;
  localparam int BIT_PD_A = 2;
  localparam int BIT_PD_B = 3;
  localparam int ST_ARMED = 0;
  localparam int ST_PENDING = 1;
  localparam int ST_PD_A = 2;
  localparam int ST_PD_B = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } dcb_sample_s;
endpackage

// file: rtl/dcb_top.sv
// Channel binding, NCO reference divisor and NCO phase sync control with AXI4-Lite registers.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dcb_top (
  input wire logic i_clk, // Device clock, 25 MHz.
  input wire logic i_sys_rst, // Asynchronous reset, active high.
  input wire logic [dcb_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [dcb_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire dcb_pkg::dcb_sample_s i_conv_a, // Converter A sample stream.
  input wire dcb_pkg::dcb_sample_s i_conv_b, // Converter B sample stream.
  output dcb_pkg::dcb_sample_s o_dig_a, // Digital channel A input stream.
  output dcb_pkg::dcb_sample_s o_dig_b, // Digital channel B input stream.
  output logic [1:0] o_chan_pd, // Digital channel and link power down, bit 0 is A.
  output logic o_serial_link_enable, // Serial link enable.
  output logic o_cal_enable, // Calibration enable.
  output logic [15:0] o_ref_divisor, // Reference divisor shared by all presets.
  output logic o_ref_div_en, // High when the divisor is active.
  input wire logic i_sysref, // SYSREF level.
  input wire logic i_link_sync_n, // Link sync request from the receiver, active low.
  input wire logic i_mf_boundary, // Multiframe or multiblock boundary pulse.
  input wire logic i_enc_64b66b, // High in 64B/66B encoding, low in 8B/10B.
  output logic o_link_sync_n, // Sync request passed on to the link in 8B/10B, held high in 64B/66B; active low.
  output logic o_phase_init // One-cycle NCO phase initialization pulse.
);
  import dcb_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] route_r, sync_ctl_r, path_ctl_r;
  logic [15:0] ref_div_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_ROUTE || a == ADDR_REF_DIV || a == ADDR_SYNC_CTL || a == ADDR_PATH_CTL || a == ADDR_STATUS;
  endfunction

  // Selects what a digital channel sees from the converter it is bound to.
  function automatic dcb_sample_s pick_sample(input logic sel, input dcb_sample_s from_a, input dcb_sample_s from_b);
    return sel ? from_b : from_a;
  endfunction

  function automatic logic pick_pd(input logic sel, input logic pd_from_a, input logic pd_from_b);
    return sel ? pd_from_b : pd_from_a;
  endfunction

  wire do_write = aw_held_r && w_held_r && !bvalid_r;
  wire do_read = s_axi_arvalid && !rvalid_r;
  wire wr_route = do_write && awaddr_r == ADDR_ROUTE;
  wire wr_div = do_write && awaddr_r == ADDR_REF_DIV;
  wire wr_sync = do_write && awaddr_r == ADDR_SYNC_CTL;
  wire wr_path = do_write && awaddr_r == ADDR_PATH_CTL;
  wire [31:0] route_nxt = merge({24'h0, route_r}, wdata_r, wstrb_r);
  wire [31:0] div_nxt = merge({16'h0, ref_div_r}, wdata_r, wstrb_r);
  wire [31:0] sync_nxt = merge({24'h0, sync_ctl_r}, wdata_r, wstrb_r);
  wire [31:0] path_nxt = merge({24'h0, path_ctl_r}, wdata_r, wstrb_r);
  logic armed_r, pending_r;
  wire [7:0] status = {4'h0, o_chan_pd[1], o_chan_pd[0], pending_r, armed_r};
  wire [31:0] rd_mux = s_axi_araddr == ADDR_ROUTE ? {24'h0, route_r} :
                       s_axi_araddr == ADDR_REF_DIV ? {16'h0, ref_div_r} :
                       s_axi_araddr == ADDR_SYNC_CTL ? {24'h0, sync_ctl_r} :
                       s_axi_araddr == ADDR_PATH_CTL ? {24'h0, path_ctl_r} :
                       s_axi_araddr == ADDR_STATUS ? {24'h0, status} : 32'h0;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_read) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Reserved bits are writable storage and read back as written.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      route_r <= RST_ROUTE;
      ref_div_r <= RST_REF_DIV;
      sync_ctl_r <= RST_SYNC_CTL;
      path_ctl_r <= RST_PATH_CTL;
    end else begin
      if (wr_route) begin
        route_r <= route_nxt[7:0];
      end
      if (wr_div) begin
        ref_div_r <= div_nxt[15:0];
      end
      if (wr_sync) begin
        sync_ctl_r <= sync_nxt[7:0];
      end
      if (wr_path) begin
        path_ctl_r <= path_nxt[7:0];
      end
    end
  end

  // ****************************************
  // Channel binding and power down
  // ****************************************
  wire route_a = route_r[BIT_ROUTE_A];
  wire route_b = route_r[BIT_ROUTE_B];
  wire pd_a = path_ctl_r[BIT_PD_A];
  wire pd_b = path_ctl_r[BIT_PD_B];
  wire dig_a_pd_nxt = pick_pd(route_a, pd_a, pd_b);
  wire dig_b_pd_nxt = pick_pd(route_b, pd_a, pd_b);
  wire dcb_sample_s dig_a_nxt = pick_sample(route_a, i_conv_a, i_conv_b);
  wire dcb_sample_s dig_b_nxt = pick_sample(route_b, i_conv_a, i_conv_b);
  dcb_sample_s dig_a_r, dig_b_r;
  logic [1:0] chan_pd_r;

  // A powered-down channel carries no valid samples and holds zero data.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dig_a_r <= '0;
      dig_b_r <= '0;
      chan_pd_r <= 2'h0;
    end else begin
      dig_a_r <= dig_a_pd_nxt ? '0 : dig_a_nxt;
      dig_b_r <= dig_b_pd_nxt ? '0 : dig_b_nxt;
      chan_pd_r <= {dig_b_pd_nxt, dig_a_pd_nxt};
    end
  end

  assign o_dig_a = dig_a_r;
  assign o_dig_b = dig_b_r;
  assign o_chan_pd = chan_pd_r;
  assign o_serial_link_enable = path_ctl_r[BIT_LINK_EN];
  assign o_cal_enable = path_ctl_r[BIT_CAL_EN];
  assign o_ref_divisor = ref_div_r;
  assign o_ref_div_en = ref_div_r != 16'h0000;

  // ****************************************
  // NCO phase synchronization
  // ****************************************
  // The link sync history resets high, so a sync already released high at reset shows no false rising edge.
  logic sysref_q_r, sync_q_r, arm_q_r, init_r;
  wire align_sync = sync_ctl_r[BIT_ALIGN_SYNC];
  wire arm_bit = sync_ctl_r[BIT_SYSREF_ARM];
  wire sysref_rise = i_sysref && !sysref_q_r;
  wire sync_rise = i_link_sync_n && !sync_q_r;
  wire arm_rise = arm_bit && !arm_q_r;
  wire sysref_fire = armed_r && sysref_rise;
  wire sync_fire = align_sync && pending_r && i_mf_boundary;
  // When arming and a SYSREF rise meet in one cycle, arming wins and the flag stays set.
  wire armed_nxt = arm_rise ? 1'b1 : (sysref_fire ? 1'b0 : armed_r);
  wire pending_nxt = (align_sync && sync_rise) ? 1'b1 : ((sync_fire || !align_sync) ? 1'b0 : pending_r);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sysref_q_r <= 1'b0;
      sync_q_r <= 1'b1;
      arm_q_r <= 1'b0;
      armed_r <= 1'b0;
      pending_r <= 1'b0;
      init_r <= 1'b0;
    end else begin
      sysref_q_r <= i_sysref;
      sync_q_r <= i_link_sync_n;
      arm_q_r <= arm_bit;
      armed_r <= armed_nxt;
      pending_r <= pending_nxt;
      init_r <= sysref_fire || sync_fire;
    end
  end

  assign o_phase_init = init_r;
  assign o_link_sync_n = i_enc_64b66b ? 1'b1 : i_link_sync_n;

  // ****************************************
  // Checks
  // ****************************************
  route_b_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !dig_b_pd_nxt |=> o_dig_b == ($past(route_b) ? $past(i_conv_b) : $past(i_conv_a)))
    else $error("Channel B route mismatch");
  route_a_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !dig_a_pd_nxt && $stable(route_r) |=> o_dig_a == ($past(route_a) ? $past(i_conv_b) : $past(i_conv_a)))
    else $error("Channel A route mismatch");
  chan_power_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_chan_pd[0] == ($past(route_a) ? $past(pd_b) : $past(pd_a)))
    else $error("Channel A power down mismatch");
  chan_power_b_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_chan_pd[1] == ($past(route_b) ? $past(pd_b) : $past(pd_a)))
    else $error("Channel B power down mismatch");
  dig_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_chan_pd[0] || o_dig_a == '0) && (!o_chan_pd[1] || o_dig_b == '0))
    else $error("Powered-down channel carries samples");
  div_enable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_div && div_nxt[15:0] == 16'h0 |=> !o_ref_div_en)
    else $error("Divisor enabled at zero");
  sync_align_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    align_sync && sync_rise ##1 (!i_mf_boundary && align_sync)[*2] ##1 (i_mf_boundary && align_sync) |=> o_phase_init)
    else $error("Link sync alignment missed");
  link_iso_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_enc_64b66b |-> o_link_sync_n)
    else $error("Sync reached link in 64B/66B");
  sysref_init_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(arm_bit) ##1 (!sysref_rise && !sync_fire) ##1 sysref_rise |=> o_phase_init)
    else $error("Armed SYSREF did not init phase");
  sysref_once_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sysref_fire && !arm_rise |=> !armed_r ##1 (!armed_r || $past(arm_rise)))
    else $error("SYSREF armed flag not cleared");
  arm_detect_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(arm_q_r) |-> armed_r)
    else $error("Arm transition not detected");
  div_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_div && wstrb_r[1:0] == 2'h3 |=> o_ref_divisor == $past(wdata_r[15:0]))
    else $error("Divisor write not applied");
  div_active_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_div && div_nxt[15:0] != 16'h0000 |=> o_ref_div_en)
    else $error("Divisor not enabled when nonzero");
  init_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_phase_init |-> $past(i_mf_boundary && align_sync) || $past(sysref_rise))
    else $error("Phase init without boundary or SYSREF");
  pending_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(align_sync) |=> !pending_r)
    else $error("Sync pending kept after align cleared");
  link_pass_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_enc_64b66b |-> o_link_sync_n == i_link_sync_n)
    else $error("Sync not passed to link in 8B/10B");
  sysref_fire_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    armed_r && sysref_rise |=> o_phase_init)
    else $error("Armed SYSREF rise gave no phase init");
  sysref_ignore_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !armed_r && sysref_rise && !sync_fire |=> !o_phase_init)
    else $error("Unarmed SYSREF rise gave phase init");
  armed_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(armed_r) |-> $past(arm_rise))
    else $error("Armed flag set without arm transition");

  // ****************************************
  // Bus checks
  // ****************************************
  bvalid_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before ready");
  rvalid_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read response dropped before ready");
  unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_read && !mapped(s_axi_araddr) |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR)
    else $error("Unmapped read not refused");
  unmapped_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    do_write && !mapped(awaddr_r) |=> s_axi_bresp == RESP_SLVERR && $stable({route_r, ref_div_r, sync_ctl_r, path_ctl_r}))
    else $error("Unmapped write not refused");
endmodule
`default_nettype wire

// file: tb/dcb_far_end.sv
// Far-side model: SYSREF source, link sync receiver and multiframe timing.
`timescale 1ns/10ps
`default_nettype none
module dcb_far_end (
  input wire logic i_clk, // Device clock.
  input wire logic i_sys_rst, // Reset, active high.
  input wire logic i_sysref_req, // Starts a SYSREF burst.
  input wire logic i_sync_req, // Releases the link sync request.
  output logic o_sysref, // SYSREF level.
  output logic o_link_sync_n, // Link sync request, active low.
  output logic o_mf_boundary // Multiframe boundary pulse.
);
  logic [2:0] mf_r;
  logic [2:0] sr_r;
  // SYSREF only toggles in a burst of three pulses after a request, quiet otherwise.
  assign o_sysref = sr_r[0];
  assign o_mf_boundary = (mf_r == 3'h7);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mf_r <= 3'h0;
      sr_r <= 3'h0;
      o_link_sync_n <= 1'h0;
    end else begin
      mf_r <= mf_r + 3'h1;
      sr_r <= i_sysref_req ? 3'h5 : (sr_r != 3'h0) ? sr_r - 3'h1 : 3'h0;
      o_link_sync_n <= i_sync_req;
    end
  end
endmodule
`default_nettype wire

// file: tb/dcb_top_tb.sv
// Self-checking bench for channel binding, divisor and NCO phase sync.
`timescale 1ns/10ps
`default_nettype none
module dcb_top_tb;
  import dcb_pkg::*;
  logic i_clk = 1'h0;
  logic i_sys_rst;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  // Response readies stay high, so each response is taken at the edge where it is first sampled.
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, o_chan_pd;
  dcb_sample_s i_conv_a = '0, i_conv_b = '0, o_dig_a, o_dig_b;
  logic o_serial_link_enable, o_cal_enable, o_ref_div_en, o_link_sync_n, o_phase_init;
  logic [15:0] o_ref_divisor;
  logic i_sysref, i_link_sync_n, i_mf_boundary;
  logic i_enc_64b66b = 1'h0, sysref_req = 1'h0, sync_req = 1'h0;
  int bad_count = 0, n_tests = 0, pi_cnt = 0;
  dcb_top i_dut (.i_clk, .i_sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_conv_a, .i_conv_b, .o_dig_a,
    .o_dig_b, .o_chan_pd, .o_serial_link_enable, .o_cal_enable, .o_ref_divisor, .o_ref_div_en, .i_sysref,
    .i_link_sync_n, .i_mf_boundary, .i_enc_64b66b, .o_link_sync_n, .o_phase_init);
  dcb_far_end i_far (.i_clk, .i_sys_rst, .i_sysref_req(sysref_req), .i_sync_req(sync_req), .o_sysref(i_sysref),
    .o_link_sync_n(i_link_sync_n), .o_mf_boundary(i_mf_boundary));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_phase_init === 1'h1) pi_cnt <= pi_cnt + 1;
  end
  // ****
  // Checking and bus tasks
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Handshakes are judged at the negedge, which shows what the next rising edge samples.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] rsp;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge i_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge i_clk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
    end while (hb !== 1'h1);
    chk("bresp", 32'(rsp), 32'(er));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic hr, hv;
    logic [31:0] d;
    logic [1:0] rsp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge i_clk);
      hr = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge i_clk);
      if (hr) s_axi_arvalid <= 1'h0;
    end while (hv !== 1'h1);
    chk("rdata", d, ex);
    chk("rresp", 32'(rsp), 32'(er));
  endtask
  function automatic dcb_sample_s exp_dig(input logic sel, input logic [1:0] pd, input dcb_sample_s a,
    input dcb_sample_s b);
    if (pd[sel] === 1'h1) return '0;
    return sel ? b : a;
  endfunction
  task automatic strm(input logic [1:0] rt, input logic [1:0] pd);
    dcb_sample_s a, b;
    a = dcb_sample_s'(13'($urandom));
    b = dcb_sample_s'(13'($urandom));
    i_conv_a <= a;
    i_conv_b <= b;
    @(posedge i_clk);
    @(negedge i_clk);
    chk("dig_a", 32'(o_dig_a), 32'(exp_dig(rt[0], pd, a, b)));
    chk("dig_b", 32'(o_dig_b), 32'(exp_dig(rt[1], pd, a, b)));
    chk("chan_pd", 32'(o_chan_pd), 32'({pd[rt[1]], pd[rt[0]]}));
    @(posedge i_clk);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    int c;
    logic [15:0] dv;
    i_sys_rst = 1'h1;
    void'($urandom(32'h9a928465));
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_clk);
    rdc(ADDR_ROUTE, 32'(RST_ROUTE), RESP_OKAY);
    rdc(ADDR_REF_DIV, 32'(RST_REF_DIV), RESP_OKAY);
    rdc(ADDR_SYNC_CTL, 32'(RST_SYNC_CTL), RESP_OKAY);
    rdc(ADDR_PATH_CTL, 32'(RST_PATH_CTL), RESP_OKAY);
    rdc(12'h004, 32'h0, RESP_SLVERR);
    wr(12'h004, 32'h5A, RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_PATH_CTL, {28'h0, i[1:0], 2'h0}, RESP_OKAY);
      wr(ADDR_ROUTE, {30'h0, i[3:2]}, RESP_OKAY);
      repeat (3) strm(i[3:2], i[1:0]);
    end
    wr(ADDR_ROUTE, 32'(RST_ROUTE), RESP_OKAY);
    wr(ADDR_PATH_CTL, 32'h3, RESP_OKAY);
    chk("link_cal", {30'h0, o_cal_enable, o_serial_link_enable}, 32'h3);
    wr(ADDR_PATH_CTL, 32'h0, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      dv = (i == 0) ? 16'h2000 : (i == 1) ? 16'h0000 : 16'($urandom % 8193);
      wr(ADDR_REF_DIV, {16'h0, dv}, RESP_OKAY);
      rdc(ADDR_REF_DIV, {16'h0, dv}, RESP_OKAY);
      chk("divisor", {16'h0, o_ref_divisor}, {16'h0, dv});
      chk("div_en", {31'h0, o_ref_div_en}, {31'h0, dv != 16'h0});
    end
    for (int e = 0; e < 2; e++) begin
      i_enc_64b66b <= e[0];
      sync_req <= 1'h0;
      repeat (10) @(posedge i_clk);
      @(negedge i_clk);
      chk("sync_out", {31'h0, o_link_sync_n}, {31'h0, e[0]});
      c = pi_cnt;
      @(posedge i_clk);
      sync_req <= 1'h1;
      repeat (20) @(posedge i_clk);
      chk("sync_init", 32'(pi_cnt - c), 32'h1);
    end
    wr(ADDR_PATH_CTL, 32'h1, RESP_OKAY);
    wr(ADDR_SYNC_CTL, 32'h0, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      if (k != 1) begin
        wr(ADDR_SYNC_CTL, 32'h0, RESP_OKAY);
        wr(ADDR_SYNC_CTL, 32'h1, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h1, RESP_OKAY);
      end
      c = pi_cnt;
      repeat (2) @(posedge i_clk);
      sysref_req <= 1'h1;
      @(posedge i_clk);
      sysref_req <= 1'h0;
      repeat (20) @(posedge i_clk);
      chk("sysref_init", 32'(pi_cnt - c), (k == 1) ? 32'h0 : 32'h1);
    end
    conclude();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
